// *** hdl/gcoc_checker.sv ***
// Command order checker at the graphics engine command input
// Notes on behaviour
// - Pipe control needs no fence or state
// - Pipe control valid both; optimise render only
// - Streamer allocation only from streamer command
// - Render pointers for render, video for video
// - Allocation commands may be reissued anytime
// - Common state shared by both pipelines
// - Only the fence starts reallocation
module gcoc_checker (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Command input
  input wire logic cmd_valid_in,
  input wire gcoc_pkg::gcoc_cmd_t cmd_in,
  // Executed command output
  output logic exec_valid_out,
  output gcoc_pkg::gcoc_exec_t exec_out,
  // Error report
  output logic err_valid_out,
  output gcoc_pkg::gcoc_err_t err_out,
  // Status
  output logic active_pipe_out,
  output logic fence_pending_out
);

  // Architectural tracking state
  logic active_pipe;
  logic last_drain;
  logic [3:0] common_seen;
  logic [2:0] alloc_seen;   // [0] streamer [1] render [2] video
  logic fence_pending;

  // Command decode
  wire logic [3:0] op = cmd_in.op;
  wire logic is_sel = cmd_valid_in && op == gcoc_pkg::CMD_PIPE_SELECT;
  wire logic is_pc = cmd_valid_in && op == gcoc_pkg::CMD_PIPE_CONTROL;
  wire logic is_sa = cmd_valid_in && op == gcoc_pkg::CMD_STREAMER_ALLOC;
  wire logic is_rp = cmd_valid_in && op == gcoc_pkg::CMD_RENDER_PTRS;
  wire logic is_vp = cmd_valid_in && op == gcoc_pkg::CMD_VIDEO_PTRS;
  wire logic is_fence = cmd_valid_in && op == gcoc_pkg::CMD_FENCE;
  wire logic is_work = cmd_valid_in && (op == gcoc_pkg::CMD_DRAW ||
                       op == gcoc_pkg::CMD_VIDEO_WORK);
  wire logic is_alloc = is_sa || is_rp || is_vp;
  wire logic chg = is_alloc && (cmd_in.alloc_change || cmd_in.thread_change);

  // Common state commands map to one bit each, shared by both pipes
  wire logic [3:0] common_hit = {4{cmd_valid_in}} & {
    op == gcoc_pkg::CMD_COLOR_KEY, op == gcoc_pkg::CMD_SAMPLER_LUT,
    op == gcoc_pkg::CMD_SYS_ROUTINE, op == gcoc_pkg::CMD_BASE_ADDR};

  // Allocation state needed for the active pipe: streamer plus its own
  wire logic alloc_ok = alloc_seen[0] &&
    (active_pipe == gcoc_pkg::PIPE_RENDER ? alloc_seen[1]
                                          : alloc_seen[2]);

  // Order violations; pipe control is never checked
  wire logic bad_sel = is_sel && cmd_in.pipe != active_pipe &&
                       !last_drain;
  wire logic bad_fence = is_fence && !alloc_ok;
  wire logic bad_need = is_work && fence_pending;
  wire logic bad_comm = is_work && common_seen != 4'hF;
  wire logic [2:0] err_code =
    bad_sel ? gcoc_pkg::ERR_NO_DRAIN :
    bad_fence ? gcoc_pkg::ERR_FENCE_EARLY :
    bad_need ? gcoc_pkg::ERR_NEED_FENCE :
    bad_comm ? gcoc_pkg::ERR_NO_COMMON : gcoc_pkg::ERR_NONE;
  wire logic bad = err_code != gcoc_pkg::ERR_NONE;

  // Next tracking values; a rejected command leaves the pipe and the fence demand untouched
  wire logic next_pipe = (is_sel && !bad) ? cmd_in.pipe : active_pipe;
  wire logic [2:0] alloc_hit = {is_vp, is_rp, is_sa};
  // Reissue always allowed; only a real change demands a fence
  wire logic next_pending = bad ? fence_pending :
                            chg ? 1'h1 :
                            is_fence ? 1'h0 : fence_pending;

  // Executed command; reallocation only from an accepted fence
  wire logic pc_opt = is_pc &&
                      active_pipe == gcoc_pkg::PIPE_RENDER;
  wire logic realloc = is_fence && !bad;
  // One packed assignment keeps a single driver on the whole word
  wire gcoc_pkg::gcoc_exec_t next_exec =
    {op, active_pipe, pc_opt, realloc, realloc && alloc_seen[0]};

  // Tracking registers
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_pipe <= gcoc_pkg::PIPE_RENDER;
      last_drain <= 1'h0;
      common_seen <= gcoc_pkg::COMMON_RST;
      alloc_seen <= gcoc_pkg::ALLOC_RST;
      fence_pending <= 1'h0;
    end else begin
      active_pipe <= next_pipe;
      if (cmd_valid_in) begin
        last_drain <= op == gcoc_pkg::CMD_DRAIN;
      end
      common_seen <= common_seen | common_hit;
      alloc_seen <= alloc_seen | alloc_hit;
      fence_pending <= next_pending;
    end
  end

  // Output registers; pipe control executes with no prerequisites
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      exec_valid_out <= 1'h0;
      exec_out <= '0;
      err_valid_out <= 1'h0;
      err_out <= '0;
      active_pipe_out <= gcoc_pkg::PIPE_RENDER;
      fence_pending_out <= 1'h0;
    end else begin
      exec_valid_out <= cmd_valid_in && !bad;
      exec_out <= next_exec;
      err_valid_out <= bad;
      err_out <= {err_code, op};
      active_pipe_out <= next_pipe;
      fence_pending_out <= next_pending;
    end
  end

  // Switch without a drain just before is reported
  property p_sel_drain;
    @(posedge mclk_in) disable iff (!rst_b_in)
      is_sel && cmd_in.pipe != active_pipe && !last_drain |=>
        err_valid_out && err_out.code == gcoc_pkg::ERR_NO_DRAIN;
  endproperty
  a_sel_drain: assert property (p_sel_drain)
    else $error("pipe switch without drain not flagged");

  property p_pc_free;
    @(posedge mclk_in) disable iff (!rst_b_in)
      is_pc |=> exec_valid_out && !err_valid_out;
  endproperty
  a_pc_free: assert property (p_pc_free)
    else $error("pipe control not executed");

  property p_pc_opt;
    @(posedge mclk_in) disable iff (!rst_b_in)
      exec_valid_out && exec_out.pc_opt |->
        exec_out.pipe == gcoc_pkg::PIPE_RENDER &&
        exec_out.op == gcoc_pkg::CMD_PIPE_CONTROL;
  endproperty
  a_pc_opt: assert property (p_pc_opt)
    else $error("pipe control optimisation outside render pipe");

  property p_fence_early;
    @(posedge mclk_in) disable iff (!rst_b_in)
      is_fence && alloc_seen == 3'h0 |=>
        err_valid_out && err_out.code == gcoc_pkg::ERR_FENCE_EARLY;
  endproperty
  a_fence_early: assert property (p_fence_early)
    else $error("fence before allocation state not flagged");

  property p_change_fence;
    @(posedge mclk_in) disable iff (!rst_b_in)
      chg && !bad ##1 (!is_fence [*2]) ##0 is_work |=>
        err_valid_out && err_out.code == gcoc_pkg::ERR_NEED_FENCE;
  endproperty
  a_change_fence: assert property (p_change_fence)
    else $error("work after allocation change without fence");

  property p_reissue;
    @(posedge mclk_in) disable iff (!rst_b_in)
      is_alloc && !cmd_in.alloc_change && !cmd_in.thread_change &&
      !fence_pending |=> !fence_pending_out && exec_valid_out;
  endproperty
  a_reissue: assert property (p_reissue)
    else $error("plain reissue raised a fence demand");

  property p_common;
    @(posedge mclk_in) disable iff (!rst_b_in)
      is_work && common_seen != 4'hF |=> err_valid_out && !exec_valid_out;
  endproperty
  a_common: assert property (p_common)
    else $error("work without common state not flagged");

  property p_realloc;
    @(posedge mclk_in) disable iff (!rst_b_in)
      exec_out.realloc |-> exec_valid_out &&
        exec_out.op == gcoc_pkg::CMD_FENCE;
  endproperty
  a_realloc: assert property (p_realloc)
    else $error("reallocation started by non-fence command");

  property p_err_op;
    @(posedge mclk_in) disable iff (!rst_b_in)
      err_valid_out |-> err_out.op == $past(op) && !exec_valid_out;
  endproperty
  a_err_op: assert property (p_err_op)
    else $error("error does not name offending command");

  // Every taken command gets exactly one answer
  property p_answer;
    @(posedge mclk_in) disable iff (!rst_b_in)
      cmd_valid_in |=> exec_valid_out != err_valid_out;
  endproperty
  a_answer: assert property (p_answer)
    else $error("command not answered exactly once");

  // Idle cycles must not produce an answer
  property p_quiet;
    @(posedge mclk_in) disable iff (!rst_b_in)
      !cmd_valid_in |=> !exec_valid_out && !err_valid_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("answer without a command");

  // A refused switch leaves the active pipe where it was
  property p_sel_keep;
    @(posedge mclk_in) disable iff (!rst_b_in)
      is_sel && cmd_in.pipe != active_pipe && !last_drain |=>
        active_pipe_out != $past(cmd_in.pipe);
  endproperty
  a_sel_keep: assert property (p_sel_keep)
    else $error("refused switch changed the pipe");

  // Pipe control leaves the pipe alone, so its optimisation tracks it
  property p_pc_pipe;
    @(posedge mclk_in) disable iff (!rst_b_in)
      is_pc |=> exec_out.op == gcoc_pkg::CMD_PIPE_CONTROL &&
        exec_out.pc_opt == (active_pipe_out == gcoc_pkg::PIPE_RENDER);
  endproperty
  a_pc_pipe: assert property (p_pc_pipe)
    else $error("pipe control optimisation does not follow the pipe");

  // Changing allocation state alone never starts reallocation
  property p_chg_quiet;
    @(posedge mclk_in) disable iff (!rst_b_in)
      chg |=> !exec_out.realloc && fence_pending_out;
  endproperty
  a_chg_quiet: assert property (p_chg_quiet)
    else $error("allocation change started reallocation");

endmodule

// *** shared/gcoc_pkg.sv ***
// Package for the command order checker: command codes, error codes, carriers
package gcoc_pkg;

  // Command opcodes seen at the engine input
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_DRAIN = 4'h1;       // pipeline_drain_command
  localparam logic [3:0] CMD_PIPE_SELECT = 4'h2;
  localparam logic [3:0] CMD_PIPE_CONTROL = 4'h3;
  localparam logic [3:0] CMD_STREAMER_ALLOC = 4'h4;
  localparam logic [3:0] CMD_RENDER_PTRS = 4'h5;
  localparam logic [3:0] CMD_VIDEO_PTRS = 4'h6;
  localparam logic [3:0] CMD_FENCE = 4'h7;       // buffer_fence_command
  localparam logic [3:0] CMD_BASE_ADDR = 4'h8;
  localparam logic [3:0] CMD_SYS_ROUTINE = 4'h9;
  localparam logic [3:0] CMD_SAMPLER_LUT = 4'hA;
  localparam logic [3:0] CMD_COLOR_KEY = 4'hB;
  localparam logic [3:0] CMD_DRAW = 4'hC;
  localparam logic [3:0] CMD_VIDEO_WORK = 4'hD;

  // Error codes
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_NO_DRAIN = 3'h1;
  localparam logic [2:0] ERR_FENCE_EARLY = 3'h2;
  localparam logic [2:0] ERR_NEED_FENCE = 3'h3;
  localparam logic [2:0] ERR_NO_COMMON = 3'h4;

  // Pipeline select values
  localparam logic PIPE_RENDER = 1'h0;
  localparam logic PIPE_VIDEO = 1'h1;

  // Reset values
  localparam logic [3:0] COMMON_RST = 4'h0;
  localparam logic [2:0] ALLOC_RST = 3'h0;

  // Incoming command: opcode plus the flags the ordering logic needs
  typedef struct packed {
    logic [3:0] op;
    logic pipe;          // Target pipeline for pipe select
    logic alloc_change;  // Entry count or allocation size changed
    logic thread_change; // Max threads of geometry/trimming unit changed
  } gcoc_cmd_t;

  // Executed command forwarded downstream
  typedef struct packed {
    logic [3:0] op;
    logic pipe;          // Pipeline active when issued
    logic pc_opt;        // Pipe control optimisations enabled
    logic realloc;       // Start buffer deallocation/reallocation
    logic fence_stream;  // Fence includes the streamer unit
  } gcoc_exec_t;

  // Error report
  typedef struct packed {
    logic [2:0] code;
    logic [3:0] op;
  } gcoc_err_t;

endpackage

// *** tb/gcoc_checker_bench.sv ***
// Self-checking bench for the command order checker
module gcoc_checker_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cmd_valid_in;
  gcoc_pkg::gcoc_cmd_t cmd_in;
  logic exec_valid_out, err_valid_out, active_pipe_out, fence_pending_out;
  gcoc_pkg::gcoc_exec_t exec_out;
  gcoc_pkg::gcoc_err_t err_out;
  int n_errors = 0;
  int cmp_count = 0;

  // 10 MHz clock
  always #50 mclk_in = ~mclk_in;

  gcoc_producer prod (
    .mclk_in(mclk_in),
    .cmd_valid_out(cmd_valid_in),
    .cmd_out(cmd_in)
  );

  gcoc_checker DUT (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in),
    .exec_valid_out(exec_valid_out),
    .exec_out(exec_out),
    .err_valid_out(err_valid_out),
    .err_out(err_out),
    .active_pipe_out(active_pipe_out),
    .fence_pending_out(fence_pending_out)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Send one word and judge its one-cycle answer; code 0 means accepted
  task automatic issue(input logic [3:0] op, input logic [2:0] code,
      input logic pipe = 1'b0, input logic ac = 1'b0, input logic tc = 1'b0);
    prod.send(gcoc_pkg::gcoc_cmd_t'{op, pipe, ac, tc});
    check({6'h00, exec_valid_out, err_valid_out},
        {6'h00, code == 3'h0, code != 3'h0});
    if (code != 3'h0) begin
      check({1'h0, err_out}, {1'h0, code, op});
    end else begin
      check({4'h0, exec_out.op}, {4'h0, op});
    end
  endtask

  // Cold start: pipe control needs nothing, fence needs both alloc states
  task automatic t_cold();
    issue(gcoc_pkg::CMD_PIPE_CONTROL, 3'h0);
    check({7'h00, exec_out.pc_opt}, 8'h01);
    issue(gcoc_pkg::CMD_DRAW, gcoc_pkg::ERR_NO_COMMON);
    issue(gcoc_pkg::CMD_FENCE, gcoc_pkg::ERR_FENCE_EARLY);
    issue(gcoc_pkg::CMD_STREAMER_ALLOC, 3'h0);
    issue(gcoc_pkg::CMD_FENCE, gcoc_pkg::ERR_FENCE_EARLY);
    issue(gcoc_pkg::CMD_RENDER_PTRS, 3'h0);
    issue(gcoc_pkg::CMD_FENCE, 3'h0);
    check({6'h00, exec_out.realloc, fence_pending_out}, 8'h02);
    check({7'h00, exec_out.fence_stream}, 8'h01);
  endtask

  // Reissued pointers with allocation or thread changes demand a fence
  task automatic t_refence();
    issue(gcoc_pkg::CMD_RENDER_PTRS, 3'h0, 1'b0, 1'b1);
    check({6'h00, exec_out.realloc, fence_pending_out}, 8'h01);
    issue(gcoc_pkg::CMD_DRAW, gcoc_pkg::ERR_NEED_FENCE);
    issue(gcoc_pkg::CMD_FENCE, 3'h0);
    check({7'h00, fence_pending_out}, 8'h00);
    issue(gcoc_pkg::CMD_RENDER_PTRS, 3'h0, 1'b0, 1'b0, 1'b1);
    issue(gcoc_pkg::CMD_DRAW, gcoc_pkg::ERR_NEED_FENCE);
    issue(gcoc_pkg::CMD_FENCE, 3'h0);
  endtask

  // All four common commands unlock drawing
  task automatic t_common();
    for (int i = 8; i < 12; i++) begin
      issue(4'(i), 3'h0);
    end
    issue(gcoc_pkg::CMD_DRAW, 3'h0);
  endtask

  // Switch needs an adjacent drain; common state survives the switch
  task automatic t_pipe();
    issue(gcoc_pkg::CMD_DRAIN, 3'h0);
    issue(gcoc_pkg::CMD_NOP, 3'h0);
    issue(gcoc_pkg::CMD_PIPE_SELECT, gcoc_pkg::ERR_NO_DRAIN, 1'b1);
    check({7'h00, active_pipe_out}, 8'h00);
    issue(gcoc_pkg::CMD_DRAIN, 3'h0);
    issue(gcoc_pkg::CMD_PIPE_SELECT, 3'h0, 1'b1);
    check({7'h00, active_pipe_out}, 8'h01);
    issue(gcoc_pkg::CMD_PIPE_CONTROL, 3'h0);
    check({7'h00, exec_out.pc_opt}, 8'h00);
    check({7'h00, exec_out.pipe}, 8'h01);
    issue(gcoc_pkg::CMD_VIDEO_WORK, 3'h0);
    issue(gcoc_pkg::CMD_FENCE, gcoc_pkg::ERR_FENCE_EARLY);
    issue(gcoc_pkg::CMD_VIDEO_PTRS, 3'h0);
    issue(gcoc_pkg::CMD_FENCE, 3'h0);
  endtask

  // Mid-run reset clears tracking; render pointers alone cannot fence
  task automatic t_reset();
    @(posedge mclk_in);
    #1;
    rst_b_in = 1'b0;
    #1;
    check({6'h00, active_pipe_out, fence_pending_out}, 8'h00);
    repeat (2) @(posedge mclk_in);
    #1;
    rst_b_in = 1'b1;
    issue(gcoc_pkg::CMD_RENDER_PTRS, 3'h0);
    issue(gcoc_pkg::CMD_FENCE, gcoc_pkg::ERR_FENCE_EARLY);
    issue(gcoc_pkg::CMD_VIDEO_WORK, gcoc_pkg::ERR_NO_COMMON);
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs about 10 us, allow ten times that
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end

  // Reset for 20 cycles, then the scenarios
  initial begin
    repeat (20) @(posedge mclk_in);
    #1;
    rst_b_in = 1'b1;
    t_cold();
    t_refence();
    t_common();
    t_pipe();
    t_reset();
    finish_test();
  end
endmodule

// *** tb/gcoc_producer.sv ***
// Command producer model feeding the checker input
module gcoc_producer (
  // Clock
  input wire logic mclk_in,
  // Command output
  output logic cmd_valid_out,
  output gcoc_pkg::gcoc_cmd_t cmd_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle until the bench asks for a command
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end

  // One word held across exactly one taking edge, then an idle gap
  task automatic send(input gcoc_pkg::gcoc_cmd_t c);
    @(posedge mclk_in);
    #1;
    cmd_valid_out = 1'b1;
    cmd_out = c;
    @(posedge mclk_in);
    #1;
    cmd_valid_out = 1'b0;
    cmd_out = ~c; // Released word must not look like the last one
  endtask
endmodule
